/* verification/sdc_host_model.sv */
// host-side serial master model for the stepper driver link
`timescale 1ns/1ps
module sdc_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic chip_select_low_o,
  output logic sck_o,
  output logic sdi_o,
  output logic done_o
);
  logic [15:0] rx_r;

  // idle: deselected, serial clock parked low
  initial begin
    chip_select_low_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
    done_o = 1'b0;
    rx_r = 16'h0000;
  end

  // wait a number of system clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // one frame of nb bits; each serial phase spans three samples so the
  // device always sees a stable level at least twice
  task automatic xfer(input int nb, input logic [15:0] tx);
    rx_r <= 16'h0000;
    chip_select_low_o <= 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      sdi_o <= tx[i];
      tick(3);
      sck_o <= 1'b1;
      rx_r <= {rx_r[14:0], sdo_i};
      tick(3);
      sck_o <= 1'b0;
    end
    tick(3);
    chip_select_low_o <= 1'b1;
    sdi_o <= ~sdi_o; // released line shows no stale bit
    tick(3);
    done_o <= 1'b1;
    tick(1);
    done_o <= 1'b0;
    tick(2);
  endtask : xfer
endmodule : sdc_host_model

/* verification/sdc_serial_ctrl_tb_top.sv */
// self-checking bench of the stepper driver serial control block
`timescale 1ns/1ps
module sdc_serial_ctrl_tb_top;
  import sdc_pkg::*;
  typedef struct packed {
    logic [15:0] rx;
    logic [11:0] cmd;
  } sdc_exp_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic chip_enable_low = 1'b0;
  logic pwm_cycle = 1'b0;
  logic [2:0] oc = 3'h0;
  logic [2:0] live = 3'h0;
  logic [2:0] load = 3'h0;
  logic osc = 1'b0;
  logic [1:0] trip = 2'h0;
  logic [2:0] thr;
  logic cs_low, sck, sdi, sdo, sdo_oe, sdo_wire, done, standby;
  logic [1:0] chop;
  sdc_cmd_t cmd;
  sdc_exp_t exp_q[$];
  sdc_exp_t e;
  logic [15:0] rnd = 16'h70c8;
  logic [11:0] c;
  int n_errors = 0;
  int checks = 0;
  int steps;

  always #20 clk_i = ~clk_i;

  // a released output reads as floating, never as a stale bit
  assign sdo_wire = sdo_oe ? sdo : 1'bz;

  sdc_serial_ctrl u_dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .chip_enable_low_i(chip_enable_low),
    .chip_select_low_i(cs_low),
    .sck_i(sck),
    .sdi_i(sdi),
    .sdo_o(sdo),
    .sdo_oe_o(sdo_oe),
    .pwm_cycle_i(pwm_cycle),
    .osc_cycle_i(osc),
    .oc_low_a_i(oc[0]),
    .oc_low_b_i(oc[1]),
    .oc_high_i(oc[2]),
    .trip_i(trip),
    .overtemp_i(live[2]),
    .prewarn_i(live[1]),
    .supply_low_i(live[0]),
    .load_level_i(load),
    .cmd_o(cmd),
    .chopper_on_o(chop),
    .standby_o(standby)
  );

  sdc_host_model u_host (
    .clk_i(clk_i),
    .sdo_i(sdo_wire),
    .chip_select_low_o(cs_low),
    .sck_o(sck),
    .sdi_o(sdi),
    .done_o(done)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // status word from the fault byte; load field is the live input
  function automatic logic [11:0] st(input logic [7:0] f);
    return {load, 1'b1, f};
  endfunction : st

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // note the expectation first, then run the frame
  task automatic frame(input int nb, input logic [15:0] tx,
                       input logic [15:0] rx, input logic [11:0] cw);
    exp_q.push_back('{rx, cw});
    u_host.xfer(nb, tx);
  endtask : frame

  // three chopper periods with every overcurrent input high
  task automatic oc_hits();
    repeat (3) begin
      @(posedge clk_i);
      pwm_cycle <= 1'b1;
      oc <= 3'h7;
      @(posedge clk_i);
      pwm_cycle <= 1'b0;
    end
    oc <= 3'h0;
  endtask : oc_hits

  // each finished frame is compared with the oldest note
  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(16'hffff, 16'h0000);
      end else begin
        e = exp_q.pop_front();
        check(u_host.rx_r, e.rx);
        check(16'(cmd), 16'(e.cmd));
        check(16'(chop), 16'({|e.cmd[4:1], |e.cmd[10:7]}));
        check(16'(standby),
              16'(e.cmd[10:7] == 4'h0 && e.cmd[4:1] == 4'h0));
      end
    end
  end

  // main sequence; enable held low so the link is usable
  initial begin
    @(posedge clk_i);
    rnd = lfsr(rnd);
    load <= rnd[2:0];
    live <= 3'h7;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(16'(cmd), 16'h0000);
    check(16'(standby), 16'h0001);
    check(16'(sdo_oe), 16'h0000);
    // coil b off, coil a on; live faults visible, open load still 0
    c = (rnd[11:0] & 12'hfe1) | 12'h080;
    frame(12, 16'(c), 16'(st(8'he0)), c);
    live <= 3'h0;
    $display("test faults done");
    frame(8, 16'h00a5, 16'(st(8'h00)) >> 4, c);
    $display("test short frame done");
    // sticky flags; open load a follows them, b stays off
    oc_hits();
    frame(16, 16'ha000, {st(8'h17), 4'ha}, 12'h000);
    $display("test overcurrent and chain done");
    rnd = lfsr(rnd);
    c = rnd[11:0];
    frame(12, 16'(c), 16'(st(8'h00)), c);
    $display("test clear done");
    @(posedge clk_i);
    chip_enable_low <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(16'(cmd), 16'h0000);
    check(16'(standby), 16'h0001);
    check(16'(sdo_oe), 16'h0000);
    chip_enable_low <= 1'b0;
    $display("test disable done");
    // homing: one full step per pass, mixed decay off, equal currents
    repeat (2) @(posedge clk_i);
    thr = 3'h2;
    steps = 0;
    for (int k = 0; k < 6 && steps == k; k++) begin
      c = {1'b0, 4'hb, ~k[1], 1'b0, 4'hb, k[1] ^ k[0]};
      frame(12, 16'(c), 16'(st(8'h00)), c);
      // load moves now; the next reply still shows the frozen value
      load <= (k == 3) ? 3'h0 : 3'h5;
      frame(12, 16'(c), 16'(st(8'h00)), c);
      @(posedge clk_i);
      pwm_cycle <= 1'b1;
      @(posedge clk_i);
      pwm_cycle <= 1'b0;
      repeat (210) @(posedge clk_i);
      frame(12, 16'(c), 16'(st(8'h00)), c);
      if (u_host.rx_r[11:9] > thr) begin
        steps++;
      end else begin
        // a low reading is only believed when a second read agrees
        frame(12, 16'(c), 16'(st(8'h00)), c);
        if (u_host.rx_r[11:9] > thr) begin
          steps++;
        end
      end
    end
    check(16'(steps), 16'h0003);
    $display("test homing done");
    // open load: bridge b reaches its target, bridge a never does
    @(posedge clk_i);
    pwm_cycle <= 1'b1;
    trip <= 2'h2;
    @(posedge clk_i);
    pwm_cycle <= 1'b0;
    repeat (13) begin
      @(posedge clk_i);
      osc <= 1'b1;
      @(posedge clk_i);
      osc <= 1'b0;
    end
    frame(12, 16'(c), 16'(st(8'h00)), c);
    @(posedge clk_i);
    osc <= 1'b1;
    @(posedge clk_i);
    osc <= 1'b0;
    frame(12, 16'h0000, 16'(st(8'h04)), 12'h000);
    trip <= 2'h0;
    $display("test open load done");
    for (int i = 0; i < 50 && exp_q.size() > 0; i++) begin
      @(posedge clk_i);
    end
    if (exp_q.size() > 0) begin
      n_errors++;
      $display("MISMATCH at %0t: expected replies never came", $time);
    end
    report_and_stop();
  end
endmodule : sdc_serial_ctrl_tb_top

/* verilog/sdc_defs.svh */
// constants of the stepper driver serial control block
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH
`define SDC_WORD_W 12
`define SDC_BITCNT_FULL 4'hc
`define SDC_CMD_RESET 12'h000
`define SDC_STATUS_ONE 1'b1
`define SDC_OC_HITS 2'h3
`define SDC_OC_WIN_LAST 6'h3e
`define SDC_OL_OSC_LIMIT 4'he
`define SDC_CLK_MHZ 25
`define SDC_LD_SETTLE_NS 8000
`define SDC_LD_SETTLE_CYC ((`SDC_LD_SETTLE_NS * `SDC_CLK_MHZ + 999) / 1000)
`endif

/* verilog/sdc_pkg.sv */
// types of the stepper driver serial control block
package sdc_pkg;
  typedef struct packed {
    logic mixed_decay_a;
    logic [3:0] coil_a_current;
    logic polarity_a;
    logic mixed_decay_b;
    logic [3:0] coil_b_current;
    logic polarity_b;
  } sdc_cmd_t;
  typedef struct packed {
    logic [2:0] load_level;
    logic always_one;
    logic overtemp_flag;
    logic temp_prewarning_flag;
    logic supply_low_flag;
    logic high_side_overcurrent_flag;
    logic open_load_b_flag;
    logic open_load_a_flag;
    logic low_side_overcurrent_b_flag;
    logic low_side_overcurrent_a_flag;
  } sdc_status_t;
  typedef enum logic [0:0] {
    SDC_IDLE = 1'b0,
    SDC_FRAME = 1'b1
  } sdc_link_state_t;
endpackage : sdc_pkg

/* verilog/sdc_serial_ctrl.sv */
// serial command/status link and diagnostics of a two-bridge stepper driver
`timescale 1ns/1ps
`include "sdc_defs.svh"
module sdc_serial_ctrl (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic chip_enable_low_i,
  input wire logic chip_select_low_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic pwm_cycle_i,
  input wire logic osc_cycle_i,
  input wire logic oc_low_a_i,
  input wire logic oc_low_b_i,
  input wire logic oc_high_i,
  input wire logic [1:0] trip_i,
  input wire logic overtemp_i,
  input wire logic prewarn_i,
  input wire logic supply_low_i,
  input wire logic [2:0] load_level_i,
  output sdc_pkg::sdc_cmd_t cmd_o,
  output logic [1:0] chopper_on_o,
  output logic standby_o
);
  import sdc_pkg::*;

  // a zero current code means coil off and open load detection suppressed
  function automatic logic coil_off(input logic [3:0] code);
    coil_off = (code == 4'h0);
  endfunction : coil_off

  logic disabled;
  logic sck_q_r, cs_q_r;
  logic sck_rise, sck_fall, cs_rise, cs_fall;
  sdc_link_state_t state_r, state_nxt;
  logic [`SDC_WORD_W-1:0] shift_r, shift_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic sdo_r, sdo_nxt, sdo_oe_r, sdo_oe_nxt;
  sdc_cmd_t cmd_r, cmd_nxt;
  logic [1:0] chop_r, chop_nxt;
  logic standby_r, standby_nxt;
  logic cmd_take, oc_clear, pol_flip;
  sdc_status_t status_w;
  logic [5:0] win_r, win_nxt;
  logic win_end;
  logic [2:0] oc_ev, oc_flag;
  logic [1:0] ol_flag, zero_w;
  logic ld_busy_r, ld_busy_nxt, ld_seen_r, ld_seen_nxt;
  logic [7:0] ld_cnt_r, ld_cnt_nxt;
  logic [2:0] ld_hold_r, ld_hold_nxt;

  // inputs are synchronous, so one stage of history gives the edges
  assign disabled = chip_enable_low_i;
  assign sck_rise = sck_i & ~sck_q_r;
  assign sck_fall = ~sck_i & sck_q_r;
  assign cs_rise = chip_select_low_i & ~cs_q_r;
  assign cs_fall = ~chip_select_low_i & cs_q_r;
  assign zero_w = {coil_off(cmd_r.coil_b_current),
                   coil_off(cmd_r.coil_a_current)};

  // command accepted only with a full word behind it
  assign cmd_take = ~disabled & (state_r == SDC_FRAME) & cs_rise &
                    (bitcnt_r == `SDC_BITCNT_FULL);
  assign oc_clear = cmd_take & coil_off(shift_r[4:1]) &
                    coil_off(shift_r[10:7]);
  assign pol_flip = cmd_take & ((shift_r[6] != cmd_r.polarity_a) |
                                (shift_r[0] != cmd_r.polarity_b));

  // status word assembly, constant one in the middle
  always_comb begin
    status_w.load_level = ld_busy_r ? ld_hold_r : load_level_i;
    status_w.always_one = `SDC_STATUS_ONE;
    status_w.overtemp_flag = overtemp_i;
    status_w.temp_prewarning_flag = prewarn_i;
    status_w.supply_low_flag = supply_low_i;
    status_w.high_side_overcurrent_flag = oc_flag[2];
    status_w.open_load_b_flag = ol_flag[1];
    status_w.open_load_a_flag = ol_flag[0];
    status_w.low_side_overcurrent_b_flag = oc_flag[1];
    status_w.low_side_overcurrent_a_flag = oc_flag[0];
  end

  // link next state: shift register, bit count, output bit, command
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bitcnt_nxt = bitcnt_r;
    sdo_nxt = sdo_r;
    cmd_nxt = cmd_r;
    chop_nxt = chop_r;
    standby_nxt = standby_r;
    sdo_oe_nxt = ~chip_select_low_i & ~disabled;
    if (disabled) begin
      state_nxt = SDC_IDLE;
      shift_nxt = '0;
      bitcnt_nxt = 4'h0;
      sdo_nxt = 1'b0;
      cmd_nxt = `SDC_CMD_RESET;
      chop_nxt = 2'h0;
      standby_nxt = 1'b1;
    end else begin
      unique case (state_r)
        SDC_IDLE: begin
          if (cs_fall) begin
            shift_nxt = status_w;
            sdo_nxt = status_w[`SDC_WORD_W-1];
            bitcnt_nxt = 4'h0;
            state_nxt = SDC_FRAME;
          end
        end
        SDC_FRAME: begin
          if (cs_rise) begin
            state_nxt = SDC_IDLE;
            if (cmd_take) begin
              cmd_nxt = shift_r;
              chop_nxt = {~coil_off(shift_r[4:1]),
                          ~coil_off(shift_r[10:7])};
              standby_nxt = oc_clear;
            end
          end else if (sck_rise) begin
            shift_nxt = {shift_r[`SDC_WORD_W-2:0], sdi_i};
            if (bitcnt_r != `SDC_BITCNT_FULL) begin
              bitcnt_nxt = bitcnt_r + 4'h1;
            end
          end else if (sck_fall) begin
            sdo_nxt = shift_r[`SDC_WORD_W-1];
          end
        end
      endcase
    end
  end

  // link registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_q_r <= 1'b0;
      cs_q_r <= 1'b1;
      state_r <= SDC_IDLE;
      shift_r <= '0;
      bitcnt_r <= 4'h0;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
      cmd_r <= `SDC_CMD_RESET;
      chop_r <= 2'h0;
      standby_r <= 1'b1;
    end else begin
      sck_q_r <= sck_i;
      cs_q_r <= chip_select_low_i;
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      bitcnt_r <= bitcnt_nxt;
      sdo_r <= sdo_nxt;
      sdo_oe_r <= sdo_oe_nxt;
      cmd_r <= cmd_nxt;
      chop_r <= chop_nxt;
      standby_r <= standby_nxt;
    end
  end

  assign sdo_o = sdo_r;
  assign sdo_oe_o = sdo_oe_r;
  assign cmd_o = cmd_r;
  assign chopper_on_o = chop_r;
  assign standby_o = standby_r;

  // shared 63 pwm-cycle window for all overcurrent counters
  assign win_end = pwm_cycle_i & (win_r == `SDC_OC_WIN_LAST);
  always_comb begin
    win_nxt = win_r;
    if (disabled) begin
      win_nxt = 6'h00;
    end else if (pwm_cycle_i) begin
      win_nxt = win_end ? 6'h00 : win_r + 6'h01;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_r <= 6'h00;
    end else begin
      win_r <= win_nxt;
    end
  end

  // overcurrent sources, sampled once per pwm cycle
  assign oc_ev = {oc_high_i, oc_low_b_i, oc_low_a_i};
  for (genvar g = 0; g < 3; g++) begin : g_oc
    logic [1:0] cnt_r, cnt_nxt;
    logic flag_r, flag_nxt, hit;
    assign hit = pwm_cycle_i & oc_ev[g];
    // the third hit in a window landing with a clearing command still sets the flag
    always_comb begin
      cnt_nxt = cnt_r;
      flag_nxt = flag_r & ~oc_clear;
      if (disabled) begin
        cnt_nxt = 2'h0;
        flag_nxt = 1'b0;
      end else begin
        if (hit && cnt_r == `SDC_OC_HITS - 2'h1) begin
          flag_nxt = 1'b1;
        end
        if (win_end) begin
          cnt_nxt = 2'h0;
        end else if (hit && cnt_r != `SDC_OC_HITS) begin
          cnt_nxt = cnt_r + 2'h1;
        end
      end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt_r <= 2'h0;
        flag_r <= 1'b0;
      end else begin
        cnt_r <= cnt_nxt;
        flag_r <= flag_nxt;
      end
    end
    assign oc_flag[g] = flag_r;
  end

  // open load watch per bridge, restarted every chopper period
  for (genvar b = 0; b < 2; b++) begin : g_ol
    logic [3:0] osc_r, osc_nxt;
    logic reach_r, reach_nxt, miss_r, miss_nxt;
    always_comb begin
      osc_nxt = osc_r;
      reach_nxt = reach_r | trip_i[b];
      miss_nxt = miss_r;
      if (disabled || zero_w[b]) begin
        osc_nxt = 4'h0;
        reach_nxt = 1'b0;
        miss_nxt = 1'b0;
      end else if (pwm_cycle_i) begin
        osc_nxt = 4'h0;
        reach_nxt = 1'b0;
      end else if (trip_i[b]) begin
        miss_nxt = 1'b0;
      end else if (osc_cycle_i && !reach_r) begin
        if (osc_r == `SDC_OL_OSC_LIMIT - 4'h1) begin
          miss_nxt = 1'b1;
        end
        if (osc_r != `SDC_OL_OSC_LIMIT) begin
          osc_nxt = osc_r + 4'h1;
        end
      end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        osc_r <= 4'h0;
        reach_r <= 1'b0;
        miss_r <= 1'b0;
      end else begin
        osc_r <= osc_nxt;
        reach_r <= reach_nxt;
        miss_r <= miss_nxt;
      end
    end
    // faults force the flag, a coil switched off forces it low
    assign ol_flag[b] = ~zero_w[b] & (miss_r | (|oc_flag) | supply_low_i |
                        overtemp_i);
  end

  // load value frozen after a polarity change until the next chopper period starts, plus the settle time
  always_comb begin
    ld_busy_nxt = ld_busy_r;
    ld_seen_nxt = ld_seen_r;
    ld_cnt_nxt = ld_cnt_r;
    ld_hold_nxt = ld_hold_r;
    if (disabled) begin
      ld_busy_nxt = 1'b0;
      ld_seen_nxt = 1'b0;
      ld_cnt_nxt = 8'h00;
      ld_hold_nxt = 3'h0;
    end else if (pol_flip) begin
      ld_busy_nxt = 1'b1;
      ld_seen_nxt = 1'b0;
      ld_cnt_nxt = 8'(`SDC_LD_SETTLE_CYC);
      ld_hold_nxt = status_w.load_level;
    end else if (ld_busy_r) begin
      if (!ld_seen_r) begin
        ld_seen_nxt = pwm_cycle_i;
      end else if (ld_cnt_r == 8'h01) begin
        ld_busy_nxt = 1'b0;
      end else begin
        ld_cnt_nxt = ld_cnt_r - 8'h01;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ld_busy_r <= 1'b0;
      ld_seen_r <= 1'b0;
      ld_cnt_r <= 8'h00;
      ld_hold_r <= 3'h0;
    end else begin
      ld_busy_r <= ld_busy_nxt;
      ld_seen_r <= ld_seen_nxt;
      ld_cnt_r <= ld_cnt_nxt;
      ld_hold_r <= ld_hold_nxt;
    end
  end

  // checks on the link and the diagnostics
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_open;
    !disabled && state_r == SDC_IDLE && cs_fall;
  endsequence
  sequence s_flip;
    pol_flip && !disabled;
  endsequence
  chk_output_release: assert property (
    sdo_oe_o |-> $past(!chip_select_low_i && !chip_enable_low_i))
    else $error("output enabled while deselected or disabled");
  chk_status_capture: assert property (
    s_open |=> shift_r == $past(status_w) && sdo_o == shift_r[11])
    else $error("status not loaded at select fall");
  chk_shift_in: assert property (
    !disabled && state_r == SDC_FRAME && sck_rise && !cs_rise
    |=> shift_r == {$past(shift_r[10:0]), $past(sdi_i)})
    else $error("input bit not shifted in at clock rise");
  chk_shift_out: assert property (
    !disabled && state_r == SDC_FRAME && sck_fall && !cs_rise
    |=> sdo_o == $past(shift_r[11]))
    else $error("output bit not updated after clock fall");
  chk_short_frame: assert property (
    !disabled && state_r == SDC_FRAME && cs_rise &&
    bitcnt_r < `SDC_BITCNT_FULL
    |=> $stable(cmd_r))
    else $error("short frame changed the command");
  chk_cmd_latch: assert property (
    cmd_take |=> cmd_r == $past(shift_r) && state_r == SDC_IDLE)
    else $error("command not latched at select rise");
  chk_disable_clear: assert property (
    disabled |=> cmd_r == 12'h000 && oc_flag == 3'h0 && !sdo_oe_o)
    else $error("disable did not clear registers");
  chk_both_zero: assert property (
    oc_clear |=> standby_o && chopper_on_o == 2'h0)
    else $error("zero currents did not enter standby");
  chk_open_zero: assert property (
    zero_w[0] |-> !status_w.open_load_a_flag)
    else $error("open load reported on a coil that is off");
  chk_oc_third: assert property (
    !disabled && g_oc[0].hit && g_oc[0].cnt_r == 2'h2
    |=> oc_flag[0])
    else $error("third overcurrent hit did not set the flag");
  chk_load_freeze: assert property (
    s_flip ##1 (!disabled)[*8] |-> $stable(status_w.load_level) &&
    ld_busy_r)
    else $error("load value not held after polarity toggle");
endmodule : sdc_serial_ctrl
